// ==== tpc_params.svh ====
// Register offsets, field positions and reset values of the timer, PWM and DMA block.
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

`define TPC_OFS_MODE 8'h00
`define TPC_OFS_IRQ_EN 8'h04
`define TPC_OFS_IRQ_FLAG 8'h08
`define TPC_OFS_FIFO_LEVEL 8'h0C
`define TPC_OFS_COUNT 8'h10
`define TPC_OFS_END 8'h14
`define TPC_OFS_FIFO 8'h18
`define TPC_OFS_DMA_CTRL 8'h1C
`define TPC_OFS_DMA_NOW 8'h20
`define TPC_OFS_DMA_BEG 8'h24
`define TPC_OFS_DMA_END 8'h28

`define TPC_MODE_INPUT 0
`define TPC_MODE_CLEAR 1
`define TPC_MODE_RUN 2
`define TPC_MODE_DRIVE 3
`define TPC_MODE_POLAR 4
`define TPC_MODE_REP_LO 5
`define TPC_MODE_EDGECNT 7
`define TPC_MODE_PWM 8
`define TPC_MODE_EDGE_LO 9
`define TPC_MODE_WIDTH 11
`define TPC_MODE_RESET 11'h000

`define TPC_FLAG_CYC 0
`define TPC_FLAG_ACT 1
`define TPC_FLAG_HALF 2
`define TPC_FLAG_DMA 3
`define TPC_FLAG_OV 4
`define TPC_FLAG_WIDTH 5
`define TPC_FLAG_RESET 5'h00

`define TPC_DMA_ON 0
`define TPC_DMA_WRAP 2
`define TPC_DMA_CTRL_RESET 3'h0
`define TPC_ADDR_RESET 15'h0000
`define TPC_ADDR_STEP 15'h0004
`define TPC_FIFO_HALF 4

`endif

// ==== tpc_pkg.sv ====
// Types shared by the timer, PWM and DMA block.
package tpc_pkg;
  typedef enum {TPC_TIMING, TPC_PWM, TPC_COUNTING, TPC_CAPTURE} tpc_mode_e;
  typedef enum {TPC_DMA_IDLE, TPC_DMA_WAIT} tpc_dma_e;
endpackage

// ==== tpc_fifo_if.sv ====
// Signals between the timer core and its duty-value store.
`timescale 1ns/10ps
`default_nettype none
interface tpc_fifo_if #(parameter int WIDTH = 26, parameter int LW = 4);
  logic push;
  logic [WIDTH-1:0] push_data;
  logic pop;
  logic [WIDTH-1:0] pop_data;
  logic flush;
  logic [LW-1:0] level;
  logic full;
  logic empty;
  modport owner (output push, push_data, pop, flush, input pop_data, level, full, empty);
  modport store (input push, push_data, pop, flush, output pop_data, level, full, empty);
endinterface
`default_nettype wire

// ==== tpc_fifo.sv ====
// Duty-value store: a small first-in first-out memory with level count.
`timescale 1ns/10ps
`default_nettype none
module tpc_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8,
  parameter int LW = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  tpc_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [LW-1:0] level;
  logic do_push;
  logic do_pop;

  // A push into a full store or a pop from an empty one is ignored.
  assign do_push = f.push && (level != LW'(DEPTH));
  assign do_pop = f.pop && (level != '0);
  assign f.level = level;
  assign f.full = (level == LW'(DEPTH));
  assign f.empty = (level == '0);
  assign f.pop_data = mem[rd_ptr];

  // Pointers and level; flush empties the store at once.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (f.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        level <= level + 1'b1;
      end else if (do_pop && !do_push) begin
        level <= level - 1'b1;
      end
    end
  end

  // Storage holds no reset so it can map onto plain memory.
  always_ff @(posedge mclk) begin
    if (do_push && !f.flush) begin
      mem[wr_ptr] <= f.push_data;
    end
  end
endmodule // tpc_fifo
`default_nettype wire

// ==== tpc_timer.sv ====
// Timer, edge counter and PWM unit with duty-value DMA, behind a Wishbone slave.
`include "tpc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tpc_timer
  import tpc_pkg::*;
#(
  parameter bit HAS_DMA = 1'b1,
  parameter int CNT_W = 26,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_in,
  output logic pwm_out,
  output logic pwm_oe,
  output logic irq,
  output logic dma_req,
  output logic [14:0] dma_addr,
  input wire logic [31:0] dma_rdata,
  input wire logic dma_ack
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge used by every writable control register; flag clears and store pushes bypass it.
  function automatic logic [31:0] merge32(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [`TPC_MODE_WIDTH-1:0] mode_ctrl;
  logic [`TPC_FLAG_WIDTH-1:0] irq_en;
  logic [`TPC_FLAG_WIDTH-1:0] flags;
  logic [CNT_W-1:0] count_end_value;
  logic [CNT_W-1:0] current_count;
  logic [2:0] dma_ctrl;
  logic [14:0] dma_start;
  logic [14:0] dma_end;
  logic [14:0] dma_ptr;
  logic [CNT_W-1:0] duty;
  logic duty_valid;
  logic [3:0] rep_cnt;
  logic in_prev;
  tpc_dma_e dma_state;
  tpc_mode_e mode;
  tpc_fifo_if #(.WIDTH(CNT_W), .LW(LW)) fq ();

  logic bus_req;
  logic wr_hit;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic full_clear;
  logic count_run;
  logic step;
  logic wrap;
  logic [CNT_W:0] next_count;
  logic edge_hit;
  logic [3:0] rep_target;
  logic need_load;
  logic act_end;
  logic half_set;
  logic ov_set;
  logic dma_push;
  logic dma_done_set;
  logic [`TPC_FLAG_WIDTH-1:0] flag_w1c;
  logic ptr_reload;
  logic sw_push;
  logic [14:0] ptr_step;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode from the control bits.
  assign full_clear = mode_ctrl[`TPC_MODE_CLEAR];
  assign count_run = mode_ctrl[`TPC_MODE_RUN];
  always_comb begin
    if (mode_ctrl[`TPC_MODE_INPUT]) begin
      mode = mode_ctrl[`TPC_MODE_EDGECNT] ? TPC_COUNTING : TPC_CAPTURE;
    end else begin
      mode = mode_ctrl[`TPC_MODE_PWM] ? TPC_PWM : TPC_TIMING;
    end
  end

  // Pin edge detect; the pin is taken as synchronous to mclk.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= timer_in;
    end
  end

  // Edge field: 01 any edge, 10 falling, 11 rising, 00 none.
  always_comb begin
    case (mode_ctrl[`TPC_MODE_EDGE_LO +: 2])
      2'h1: edge_hit = timer_in ^ in_prev;
      2'h2: edge_hit = in_prev & ~timer_in;
      2'h3: edge_hit = timer_in & ~in_prev;
      default: edge_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step source: clock in timing and PWM, selected edges in counting mode.
  // Capture is not built, so an input-mode timer without the count bit rests.
  assign step = count_run && !full_clear &&
                ((mode == TPC_TIMING) || (mode == TPC_PWM) ||
                 ((mode == TPC_COUNTING) && edge_hit));
  assign next_count = {1'b0, current_count} + 1'b1;
  // The count runs 0 to end-1, so a period spans exactly end clocks.
  assign wrap = step && (next_count >= {1'b0, count_end_value});

  // Current count: held at zero by all-clear and by any end-value write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      current_count <= '0;
    end else if (full_clear) begin
      current_count <= '0;
    end else if (wr_hit && (wb_adr_i == `TPC_OFS_END)) begin
      current_count <= '0;
    end else if (wrap) begin
      current_count <= '0;
    end else if (step) begin
      current_count <= next_count[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM duty handling and repetition.
  always_comb begin
    case (mode_ctrl[`TPC_MODE_REP_LO +: 2])
      2'h0: rep_target = 4'h0;
      2'h1: rep_target = 4'h3;
      2'h2: rep_target = 4'h7;
      default: rep_target = 4'hF;
    endcase
  end
  assign need_load = (mode == TPC_PWM) && !full_clear &&
                     (!duty_valid || (wrap && (rep_cnt == rep_target)));
  assign fq.pop = need_load && !fq.empty;
  assign act_end = (mode == TPC_PWM) && step && duty_valid &&
                   (next_count == {1'b0, duty});
  assign half_set = (mode == TPC_PWM) && fq.pop &&
                    ((fq.level - 1'b1) < LW'(`TPC_FIFO_HALF));
  // Running dry at a cycle boundary keeps the old duty and flags overflow.
  assign ov_set = need_load && duty_valid && fq.empty;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      duty <= '0;
      duty_valid <= 1'b0;
      rep_cnt <= 4'h0;
    end else if (full_clear || (mode != TPC_PWM)) begin
      duty_valid <= 1'b0;
      rep_cnt <= 4'h0;
    end else if (fq.pop) begin
      duty <= fq.pop_data;
      duty_valid <= 1'b1;
      rep_cnt <= 4'h0;
    end else if (wrap && (rep_cnt != rep_target)) begin
      rep_cnt <= rep_cnt + 1'b1;
    end
  end

  // Pin: active level while count is below duty, one-clock resolution.
  // Active level is the inverse of the idle level set by the polarity bit.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
    end else begin
      pwm_oe <= mode_ctrl[`TPC_MODE_DRIVE] && count_run;
      if ((mode == TPC_PWM) && count_run && !full_clear && duty_valid &&
          (current_count < duty)) begin
        pwm_out <= ~mode_ctrl[`TPC_MODE_POLAR];
      end else begin
        pwm_out <= mode_ctrl[`TPC_MODE_POLAR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty store, fed by DMA with priority over software writes.
  assign sw_push = wr_hit && (wb_adr_i == `TPC_OFS_FIFO);
  assign fq.push = dma_push || sw_push;
  assign fq.push_data = dma_push ? dma_rdata[CNT_W-1:0] : wb_dat_i[CNT_W-1:0];
  assign fq.flush = full_clear;

  tpc_fifo #(.WIDTH(CNT_W), .DEPTH(FIFO_DEPTH), .LW(LW)) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .f(fq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // DMA reader: one outstanding word at a time, held until acknowledged.
  assign dma_push = HAS_DMA && (dma_state == TPC_DMA_WAIT) && dma_ack;
  assign ptr_step = dma_ptr + `TPC_ADDR_STEP;
  assign dma_done_set = dma_push && (ptr_step == dma_end);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_state <= TPC_DMA_IDLE;
      dma_req <= 1'b0;
      dma_addr <= `TPC_ADDR_RESET;
      dma_ptr <= `TPC_ADDR_RESET;
    end else begin
      case (dma_state)
        TPC_DMA_IDLE: begin
          if (ptr_reload) begin
            // A write to the start register loads the new value, not the one it replaces.
            dma_ptr <= (wb_adr_i == `TPC_OFS_DMA_BEG) ? wr_val[14:0] : dma_start;
          end else if (HAS_DMA && dma_ctrl[`TPC_DMA_ON] && (mode == TPC_PWM) &&
                       !full_clear && !fq.full && (dma_ptr != dma_end)) begin
            dma_req <= 1'b1;
            dma_addr <= dma_ptr;
            dma_state <= TPC_DMA_WAIT;
          end
        end
        TPC_DMA_WAIT: begin
          // A started read cannot be abandoned; it completes first.
          if (dma_ack) begin
            dma_req <= 1'b0;
            dma_state <= TPC_DMA_IDLE;
            if (dma_done_set && dma_ctrl[`TPC_DMA_WRAP]) begin
              dma_ptr <= dma_start;
            end else begin
              dma_ptr <= ptr_step;
            end
          end
        end
        default: dma_state <= TPC_DMA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: hardware set wins over a same-cycle write-one clear.
  assign flag_w1c = (wr_hit && (wb_adr_i == `TPC_OFS_IRQ_FLAG)) ?
                    (wb_dat_i[`TPC_FLAG_WIDTH-1:0] & {`TPC_FLAG_WIDTH{wb_sel_i[0]}}) : '0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags <= `TPC_FLAG_RESET;
    end else if (full_clear) begin
      flags <= `TPC_FLAG_RESET;
    end else begin
      flags[`TPC_FLAG_CYC] <= (flags[`TPC_FLAG_CYC] && !flag_w1c[`TPC_FLAG_CYC]) ||
                              (wrap && (mode != TPC_CAPTURE));
      flags[`TPC_FLAG_ACT] <= (flags[`TPC_FLAG_ACT] && !flag_w1c[`TPC_FLAG_ACT]) ||
                              act_end;
      flags[`TPC_FLAG_HALF] <= (flags[`TPC_FLAG_HALF] && !flag_w1c[`TPC_FLAG_HALF]) ||
                               half_set;
      flags[`TPC_FLAG_DMA] <= (flags[`TPC_FLAG_DMA] && !flag_w1c[`TPC_FLAG_DMA]) ||
                              dma_done_set;
      flags[`TPC_FLAG_OV] <= (flags[`TPC_FLAG_OV] && !flag_w1c[`TPC_FLAG_OV]) ||
                             ov_set;
    end
  end

  // This instance's own request line, one clock after its flag.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: answers every access one clock after the strobe.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_hit = bus_req && wb_we_i;
  assign ptr_reload = wr_hit && ((wb_adr_i == `TPC_OFS_DMA_BEG) ||
                      ((wb_adr_i == `TPC_OFS_DMA_CTRL) && wb_sel_i[0] &&
                       wb_dat_i[`TPC_DMA_ON] && !dma_ctrl[`TPC_DMA_ON]));

  // Read decode; unmapped offsets and the write-only store read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == `TPC_OFS_MODE) begin
      rd_mux[`TPC_MODE_WIDTH-1:0] = mode_ctrl;
    end else if (wb_adr_i == `TPC_OFS_IRQ_EN) begin
      rd_mux[`TPC_FLAG_WIDTH-1:0] = irq_en;
    end else if (wb_adr_i == `TPC_OFS_IRQ_FLAG) begin
      rd_mux[`TPC_FLAG_WIDTH-1:0] = flags;
    end else if (wb_adr_i == `TPC_OFS_FIFO_LEVEL) begin
      rd_mux[LW-1:0] = fq.level;
    end else if (wb_adr_i == `TPC_OFS_COUNT) begin
      rd_mux[CNT_W-1:0] = current_count;
    end else if (wb_adr_i == `TPC_OFS_END) begin
      rd_mux[CNT_W-1:0] = count_end_value;
    end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_CTRL)) begin
      rd_mux[2:0] = dma_ctrl;
    end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_NOW)) begin
      rd_mux[15:0] = {1'b0, dma_ptr};
    end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_BEG)) begin
      rd_mux[15:0] = {1'b0, dma_start};
    end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_END)) begin
      rd_mux[15:0] = {1'b0, dma_end};
    end
  end

  // Merged write value for the addressed register.
  assign wr_val = merge32(rd_mux, wb_dat_i, wb_sel_i);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

  // Writable control registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_ctrl <= `TPC_MODE_RESET;
      irq_en <= `TPC_FLAG_RESET;
      count_end_value <= '0;
      dma_ctrl <= `TPC_DMA_CTRL_RESET;
      dma_start <= `TPC_ADDR_RESET;
      dma_end <= `TPC_ADDR_RESET;
    end else if (wr_hit) begin
      if (wb_adr_i == `TPC_OFS_MODE) begin
        mode_ctrl <= wr_val[`TPC_MODE_WIDTH-1:0];
      end else if (wb_adr_i == `TPC_OFS_IRQ_EN) begin
        irq_en <= wr_val[`TPC_FLAG_WIDTH-1:0];
      end else if (wb_adr_i == `TPC_OFS_END) begin
        count_end_value <= wr_val[CNT_W-1:0];
      end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_CTRL)) begin
        dma_ctrl <= wr_val[2:0] & 3'h5;
      end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_BEG)) begin
        dma_start <= wr_val[14:0];
      end else if (HAS_DMA && (wb_adr_i == `TPC_OFS_DMA_END)) begin
        dma_end <= wr_val[14:0];
      end
    end
  end
endmodule // tpc_timer
`default_nettype wire

// ==== tpc_assertions.sv ====
// Concurrent checks on the ports of the timer, PWM and DMA block.
`timescale 1ns/10ps
`default_nettype none
module tpc_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pwm_oe,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic [14:0] dma_addr,
  input wire logic dma_ack
);
  // One clock domain, so one default clock and reset serve every property.
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////
  // Register bus answers.
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("bus answer without a request");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data driven outside an answer");

  ////////////////////////////////////////
  // Memory read port; a request must not move while the memory is still working on it.
  a_req_held: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr))
    else $error("memory request dropped or moved before its answer");
  a_req_release: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("memory request not released after its answer");
  a_addr_aligned: assert property (dma_req |-> dma_addr[1:0] == 2'b00)
    else $error("memory request to an unaligned word");
  a_quiet_release: assert property ($rose(resetn) |-> !pwm_oe && !irq && !dma_req)
    else $error("outputs active at reset release");
endmodule // tpc_assertions

bind tpc_timer tpc_assertions u_chk (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_oe(pwm_oe), .irq(irq),
  .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack));
`default_nettype wire

// ==== tpc_mem_model.sv ====
// Memory that answers the block's duty-value reads.
`timescale 1ns/10ps
`default_nettype none
module tpc_mem_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic dma_req,
  input wire logic [14:0] dma_addr,
  input wire logic [3:0] lat,
  output logic dma_ack,
  output logic [31:0] dma_rdata,
  output int fetches
);
  logic [3:0] waited;

  // Answer after lat idle cycles. Outside an answer the data lines churn, so a late
  // sample of them cannot pass on stale data.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_ack <= 1'b0;
      dma_rdata <= 32'h0;
      waited <= 4'h0;
      fetches <= 0;
    end else if (dma_req && !dma_ack && waited >= lat) begin
      dma_ack <= 1'b1;
      dma_rdata <= {6'h3F, 24'h0, dma_addr[3:2]};
      fetches <= fetches + 1;
      waited <= 4'h0;
    end else begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma_req && !dma_ack) begin
        waited <= waited + 4'h1;
      end
    end
  end
endmodule // tpc_mem_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the timer, PWM and DMA block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk, resetn, cyc, stb, we, tin, pwm, oe, irq, dreq, dack, wack;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, wq, drd;
  logic [14:0] daddr;
  logic [3:0] lat;
  int fetches, err_count, n_tests, f, n;
  int cycn = 0;
  int dt[3] = '{0, 3, 8};

  tpc_timer #(.HAS_DMA(1'b1)) u_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wq), .wb_ack_o(wack), .timer_in(tin), .pwm_out(pwm), .pwm_oe(oe), .irq(irq),
    .dma_req(dreq), .dma_addr(daddr), .dma_rdata(drd), .dma_ack(dack));
  tpc_mem_model u_mem (.mclk(mclk), .resetn(resetn), .dma_req(dreq), .dma_addr(daddr),
    .lat(lat), .dma_ack(dack), .dma_rdata(drd), .fetches(fetches));

  ////////////////////////////////////////
  // Clock and a free cycle count used to time periods.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) cycn <= cycn + 1;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single bus cycle; data is taken at the edge where the answer is seen.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge mclk);
    end while (wack !== 1'b1);
    rdat = wq;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk(irq, 1'b1);
  endtask

  ////////////////////////////////////////
  task t_regs();
    rd(8'h00); chk(rdat, 32'h0);
    rd(8'h08); chk(rdat, 32'h0);
    rd(8'h1C); chk(rdat, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40); chk(rdat, 32'h0);
    wr(8'h24, 32'hFFFF);
    rd(8'h24); chk(rdat, 32'h7FFF);
    wr(8'h28, 32'hFFFC);
    rd(8'h28); chk(rdat, 32'h7FFC);
    wr(8'h1C, 32'hFF);
    rd(8'h1C); chk(rdat, 32'h5);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h1234);
    rd(8'h20); chk(rdat, 32'h7FFF);
    $display("test regs done");
  endtask

  // Rise-to-rise of the interrupt is one full timing period.
  task t_timing();
    int c1;
    wr(8'h00, 32'h2); wr(8'h14, 32'hA); wr(8'h04, 32'h1); wr(8'h00, 32'h4);
    wait_irq();
    c1 = cycn;
    rd(8'h08); chk(rdat & 32'h1, 32'h1);
    wr(8'h08, 32'h1);
    while (irq === 1'b1) @(posedge mclk);
    wait_irq();
    chk(cycn - c1, 10);
    wr(8'h00, 32'h0);
    rd(8'h10); f = rdat;
    repeat (5) @(posedge mclk);
    rd(8'h10); chk(rdat, f);
    $display("test timing done");
  endtask

  task pulse(input int k);
    repeat (k) begin
      tin <= 1'b1;
      repeat (3) @(posedge mclk);
      tin <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask

  // Edge counting with rising, any and falling edge codes.
  task t_count();
    wr(8'h00, 32'h2); wr(8'h14, 32'h3); wr(8'h00, 32'h685);
    pulse(2); rd(8'h10); chk(rdat, 32'h2);
    pulse(1); rd(8'h10); chk(rdat, 32'h0);
    rd(8'h08); chk(rdat & 32'h1, 32'h1);
    wr(8'h00, 32'h285); wr(8'h14, 32'h3);
    pulse(2); rd(8'h10); chk(rdat, 32'h1);
    wr(8'h00, 32'h485); wr(8'h14, 32'h3);
    pulse(2); rd(8'h10); chk(rdat, 32'h2);
    wr(8'h00, 32'h085); wr(8'h14, 32'h3);
    pulse(1); rd(8'h10); chk(rdat, 32'h0);
    wr(8'h00, 32'h605);
    pulse(1); rd(8'h10); chk(rdat, 32'h0);
    $display("test count done");
  endtask

  // Active cycles in two periods of 8 for each polarity and duty.
  task t_pwm();
    int a;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 3; i++) begin
        wr(8'h00, 32'h2); wr(8'h00, 32'h0); wr(8'h14, 32'h8); wr(8'h18, dt[i]);
        wr(8'h00, 32'h10C | (p << 4));
        repeat (12) @(posedge mclk);
        a = 0;
        repeat (16) begin
          @(posedge mclk);
          if (pwm === ~p[0]) a++;
        end
        chk(a, 2 * dt[i]);
        chk(oe, 1'b1);
      end
    end
    rd(8'h08); chk(rdat & 32'h14, 32'h14);
    wr(8'h00, 32'h104);
    repeat (3) @(posedge mclk);
    chk(oe, 1'b0);
    $display("test pwm done");
  endtask

  // Each repeat code: the first duty serves 1, 4, 8 or 16 periods, then the next.
  task t_repeat();
    int rep;
    for (int c = 0; c < 4; c++) begin
      rep = (c == 0) ? 1 : (2 << c);
      wr(8'h00, 32'h2); wr(8'h00, 32'h0); wr(8'h14, 32'h4); wr(8'h18, 32'h1); wr(8'h18, 32'h3);
      wr(8'h00, 32'h108 | (c << 5)); wr(8'h00, 32'h10C | (c << 5));
      for (int i = 0; i <= rep; i++) begin
        n = 0;
        while (pwm !== 1'b1 && n < 20) begin
          @(posedge mclk);
          n++;
        end
        n = 0;
        while (pwm === 1'b1 && n < 20) begin
          @(posedge mclk);
          n++;
        end
        chk(n, (i < rep) ? 1 : 3);
      end
      rd(8'h08); chk(rdat & 32'h3, 32'h3);
    end
    $display("test repeat done");
  endtask

  // Ring fill with a slow memory, disable, all-clear, then one pass with a prompt memory.
  task t_dma();
    lat <= 4'd3;
    wr(8'h00, 32'h2); wr(8'h00, 32'h0); wr(8'h14, 32'h4);
    wr(8'h24, 32'h10); wr(8'h28, 32'h20);
    rd(8'h20); chk(rdat, 32'h10);
    wr(8'h00, 32'h100); wr(8'h1C, 32'h5);
    repeat (100) @(posedge mclk);
    rd(8'h0C); chk(rdat, 32'h8);
    rd(8'h08); chk(rdat & 32'h8, 32'h8);
    rd(8'h20); chk(rdat, 32'h10 + (fetches % 4) * 4);
    wr(8'h1C, 32'h0);
    f = fetches;
    wr(8'h00, 32'h2);
    rd(8'h0C); chk(rdat, 32'h0);
    rd(8'h08); chk(rdat, 32'h0);
    rd(8'h10); chk(rdat, 32'h0);
    wr(8'h00, 32'h104);
    repeat (60) @(posedge mclk);
    chk(fetches, f);
    lat <= 4'd0;
    wr(8'h1C, 32'h1);
    repeat (100) @(posedge mclk);
    chk(fetches - f, 4);
    rd(8'h20); chk(rdat, 32'h20);
    $display("test dma done");
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////
  // The whole run needs about a thousand cycles; the watchdog cuts a hang well beyond that.
  initial begin
    repeat (30000) @(posedge mclk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    {resetn, cyc, stb, we, tin, err_count, n_tests} = '0;
    adr = 8'h00;
    wdat = 32'h0;
    lat = 4'd1;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_timing();
    t_count();
    t_pwm();
    t_repeat();
    t_dma();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
